//--- verilog/ebb_pkg.sv
// Constants and types shared by the external memory burst buffer.
`default_nettype none
package ebb_pkg;
  localparam int ADDR_W     = 26;
  localparam int DATA_W     = 24;
  localparam int HALF_WORDS = 8;
  localparam int BUF_WORDS  = 16;
  typedef logic [ADDR_W-1:0] ebb_addr_t;
  typedef logic [DATA_W-1:0] ebb_word_t;
  typedef logic [3:0]        ebb_cnt_t;
  // Register byte offsets on the register bus.
  localparam logic [31:0] OFF_BURST_CTRL = 32'h0000_0000;
  localparam logic [31:0] OFF_MAINT      = 32'h0000_0004;
  localparam logic [31:0] OFF_STATUS     = 32'h0000_0008;
  // Burst control fields: boundary nibble and two-bit mode per space.
  localparam int XB_LSB = 0;
  localparam int XM_LSB = 4;
  localparam int YB_LSB = 8;
  localparam int YM_LSB = 12;
  localparam int PB_LSB = 16;
  localparam int PM_LSB = 20;
  localparam logic [23:0] CTRL_MASK = 24'h3F_3F3F;
  // Maintenance bits: invalidate read buffer, flush write buffer.
  localparam int INV_LSB = 0;
  localparam int FL_LSB  = 2;
  localparam logic [1:0] MODE_OUTSIDE = 2'h1;
  localparam logic [1:0] MODE_ALL     = 2'h2;
  localparam logic [1:0] SP_X         = 2'h0;
  localparam logic [1:0] SP_Y         = 2'h1;
  localparam logic [1:0] SP_P         = 2'h2;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_DECERR  = 2'h3;
  typedef enum logic [1:0] {E_IDLE, E_CMD, E_DATA} ebb_eng_t;
  typedef enum logic [1:0] {J_SWR, J_FLUSH, J_FILL, J_SRD} ebb_job_t;
  typedef struct packed {
    logic      req;
    logic      wr;
    ebb_addr_t addr;
    ebb_word_t wdata;
  } ebb_sb_req_t;
  typedef struct packed {
    logic      wr;
    ebb_addr_t addr;
    ebb_cnt_t  len;
  } ebb_mc_cmd_t;
endpackage
`default_nettype wire

//--- verilog/ebb_top.sv
// External memory burst buffer: read/write burst buffers for two bus masters.
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`default_nettype none
module ebb_top #(
  parameter logic [23:0] BURST_CTRL_RST = 24'h00_0000
) (
  // Clock and reset.
  input  wire logic                 CLK,
  input  wire logic                 RST_N,
  // Register bus, AXI4-Lite slave.
  input  wire logic [31:0]          AXI_AWADDR,
  input  wire logic                 AXI_AWVALID,
  output logic                      AXI_AWREADY,
  input  wire logic [31:0]          AXI_WDATA,
  input  wire logic [3:0]           AXI_WSTRB,
  input  wire logic                 AXI_WVALID,
  output logic                      AXI_WREADY,
  output logic [1:0]                AXI_BRESP,
  output logic                      AXI_BVALID,
  input  wire logic                 AXI_BREADY,
  input  wire logic [31:0]          AXI_ARADDR,
  input  wire logic                 AXI_ARVALID,
  output logic                      AXI_ARREADY,
  output logic [31:0]               AXI_RDATA,
  output logic [1:0]                AXI_RRESP,
  output logic                      AXI_RVALID,
  input  wire logic                 AXI_RREADY,
  // Shared bus, one request lane per master.
  input  wire ebb_pkg::ebb_sb_req_t [1:0] SB_REQ,
  output logic [1:0]                SB_ACK,
  output ebb_pkg::ebb_word_t [1:0]  SB_RDATA,
  // External memory controller.
  output logic                      MC_CMD_VALID,
  input  wire logic                 MC_CMD_READY,
  output ebb_pkg::ebb_mc_cmd_t      MC_CMD,
  output ebb_pkg::ebb_word_t        MC_WDATA,
  input  wire logic                 MC_WREADY,
  input  wire logic                 MC_RVALID,
  input  wire ebb_pkg::ebb_word_t   MC_RDATA
);
  import ebb_pkg::*;

  if ((BURST_CTRL_RST & ~CTRL_MASK) != 24'h00_0000) begin : g_chk
    $error("BURST_CTRL_RST sets bits outside the defined fields");
  end

  ebb_word_t   rmem_q [2][BUF_WORDS];
  ebb_word_t   wmem_q [2][BUF_WORDS];
  ebb_addr_t   rbase_q [2][2];
  ebb_addr_t   rbase_d [2][2];
  ebb_addr_t   wbase_q [2][2];
  ebb_addr_t   wbase_d [2][2];
  ebb_cnt_t    wcnt_q  [2][2];
  ebb_cnt_t    wcnt_d  [2][2];
  logic [1:0][1:0] rvld_q, rvld_d, rseen_q, rseen_d, rpend_q, rpend_d;
  logic [1:0][1:0] wpend_q, wpend_d, wfl;
  logic [1:0]  wcur_q, wcur_d, rfl, srd, wm_we;
  logic [1:0][3:0] wm_idx;
  logic        sw_q, sw_d, rm_we, found, hit, stall, scope, beat, c;
  ebb_addr_t   swa_q, swa_d, eaddr_q, eaddr_d;
  ebb_word_t   swd_q, swd_d;
  ebb_cnt_t    n, elen_q, elen_d;
  logic [23:0] ctrl_q, ctrl_d;
  logic [3:0]  maint_q, maint_d, ws_q, ws_d;
  ebb_eng_t    est_q, est_d;
  ebb_job_t    ejob_q, ejob_d;
  logic        em_q, em_d, eh_q, eh_d;
  logic [2:0]  ebeat_q, ebeat_d;
  logic        awv_q, awv_d, wv_q, wv_d, bv_q, bv_d, rv_q, rv_d;
  logic [31:0] awa_q, awa_d, wd_q, wd_d, rdat_q, rdat_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  ebb_sb_req_t r;
  ebb_addr_t   ofs;

  // Burst eligibility; the reserved mode falls to the no-burst default.
  function automatic logic in_scope(input logic [23:0] cfg, input ebb_addr_t a);
    logic [3:0] bnd;
    logic [1:0] md;
    bnd = 4'h0;
    md  = 2'h0;
    case (a[25:24])
      SP_X: begin bnd = cfg[XB_LSB+:4]; md = cfg[XM_LSB+:2]; end
      SP_Y: begin bnd = cfg[YB_LSB+:4]; md = cfg[YM_LSB+:2]; end
      SP_P: begin bnd = cfg[PB_LSB+:4]; md = cfg[PM_LSB+:2]; end
      default: md = 2'h0;
    endcase
    if (md == MODE_ALL) return 1'b1;
    if (md == MODE_OUTSIDE) return a[23:20] != bnd;
    return 1'b0;
  endfunction

  // Offset of an address from a half's base, which hits when below eight.
  function automatic ebb_addr_t offs(input ebb_addr_t a, input ebb_addr_t b);
    return a - b;
  endfunction

  // Jobs in flight on the controller: fills per master, flushes per master and half.
  always_comb begin
    for (int m = 0; m < 2; m++) begin
      rfl[m] = est_q != E_IDLE && ejob_q == J_FILL && em_q == 1'(m);
      for (int h = 0; h < 2; h++) begin
        wfl[m][h] = est_q != E_IDLE && ejob_q == J_FLUSH && em_q == 1'(m) && eh_q == 1'(h);
      end
    end
  end

  // Shared-bus lanes, maintenance, controller engine and register bus.
  always_comb begin
    rbase_d = rbase_q;
    rvld_d  = rvld_q;
    rseen_d = rseen_q;
    rpend_d = rpend_q;
    wbase_d = wbase_q;
    wcnt_d  = wcnt_q;
    wpend_d = wpend_q;
    wcur_d  = wcur_q;
    sw_d    = sw_q;
    swa_d   = swa_q;
    swd_d   = swd_q;
    ctrl_d  = ctrl_q;
    maint_d = maint_q;
    est_d   = est_q;
    ejob_d  = ejob_q;
    em_d    = em_q;
    eh_d    = eh_q;
    elen_d  = elen_q;
    eaddr_d = eaddr_q;
    ebeat_d = ebeat_q;
    awv_d   = awv_q;
    awa_d   = awa_q;
    wv_d    = wv_q;
    wd_d    = wd_q;
    ws_d    = ws_q;
    bv_d    = bv_q;
    bresp_d = bresp_q;
    rv_d    = rv_q;
    rdat_d  = rdat_q;
    rresp_d = rresp_q;
    SB_ACK  = 2'b00;
    SB_RDATA = '0;
    MC_CMD_VALID = 1'b0;
    wm_we   = 2'b00;
    wm_idx  = '0;
    rm_we   = 1'b0;
    srd     = 2'b00;
    found   = 1'b0;
    hit     = 1'b0;
    beat    = 1'b0;
    c       = 1'b0;
    n       = '0;
    r       = '0;
    ofs     = '0;
    scope   = 1'b0;
    stall   = 1'b0;
    for (int m = 0; m < 2; m++) begin
      r = SB_REQ[m];
      scope = in_scope(ctrl_q, r.addr);
      stall = maint_q[INV_LSB+m] | maint_q[FL_LSB+m] | sw_q;
      srd[m] = r.req & ~r.wr & ~scope & ~stall;
      hit = 1'b0;
      if (r.req && !stall && !r.wr && scope) begin
        // A hit answers in the same cycle; the other half may be filling.
        for (int h = 0; h < 2; h++) begin
          ofs = offs(r.addr, rbase_q[m][h]);
          if (!hit && rvld_q[m][h] && ofs < 26'(HALF_WORDS)) begin
            hit = 1'b1;
            SB_ACK[m] = 1'b1;
            SB_RDATA[m] = rmem_q[m][{1'(h), ofs[2:0]}];
            if (!rseen_q[m][h] && !rpend_q[m][1-h] && !rfl[m]) begin
              rseen_d[m][h] = 1'b1;
              rbase_d[m][1-h] = rbase_q[m][h] + 26'(HALF_WORDS);
              rvld_d[m][1-h] = 1'b0;
              rpend_d[m][1-h] = 1'b1;
            end
          end
        end
        // A miss refills the first half; the master waits for the hit.
        if (!hit && rpend_q[m] == 2'b00 && !rfl[m]) begin
          rbase_d[m][0] = r.addr;
          rvld_d[m][0]  = 1'b0;
          rseen_d[m][0] = 1'b0;
          rpend_d[m][0] = 1'b1;
        end
      end else if (r.req && !stall && r.wr && !scope) begin
        // Fire and forget; a second master in the same cycle waits.
        if (!sw_d) begin
          sw_d = 1'b1;
          swa_d = r.addr;
          swd_d = r.wdata;
          SB_ACK[m] = 1'b1;
        end
      end else if (r.req && !stall && r.wr) begin
        c = wcur_q[m];
        n = wcnt_q[m][c];
        if (n == 4'h0 || (n < 4'(HALF_WORDS) && r.addr == wbase_q[m][c] + 26'(n))) begin
          wm_we[m] = 1'b1;
          wm_idx[m] = {c, n[2:0]};
          wcnt_d[m][c] = 4'(n + 4'h1);
          if (n == 4'h0) wbase_d[m][c] = r.addr;
          SB_ACK[m] = 1'b1;
        end else if (wcnt_q[m][~c] == 4'h0 && !wpend_q[m][~c] && !wfl[m][~c]) begin
          wpend_d[m][c] = 1'b1;
          wcur_d[m] = ~c;
          wm_we[m] = 1'b1;
          wm_idx[m] = {~c, 3'h0};
          wcnt_d[m][~c] = 4'h1;
          wbase_d[m][~c] = r.addr;
          SB_ACK[m] = 1'b1;
        end
      end
    end
    // Maintenance requests; invalidation waits out a fill already in flight.
    for (int m = 0; m < 2; m++) begin
      if (maint_q[INV_LSB+m]) begin
        rpend_d[m] = 2'b00;
        if (!rfl[m]) begin
          rvld_d[m] = 2'b00;
          rseen_d[m] = 2'b00;
          maint_d[INV_LSB+m] = 1'b0;
        end
      end
      if (maint_q[FL_LSB+m]) begin
        for (int h = 0; h < 2; h++) begin
          if (wcnt_q[m][h] != 4'h0 && !wfl[m][h]) wpend_d[m][h] = 1'b1;
        end
        if (wcnt_q[m][0] == 4'h0 && wcnt_q[m][1] == 4'h0) maint_d[FL_LSB+m] = 1'b0;
      end
    end
    // One controller job at a time, so a second flush queues behind the first.
    case (est_q)
      E_IDLE: begin
        if (sw_q) begin
          found = 1'b1;
          ejob_d = J_SWR;
          eaddr_d = swa_q;
          elen_d = 4'h1;
        end
        for (int m = 0; m < 2; m++) begin
          for (int h = 0; h < 2; h++) begin
            if (!found && wpend_q[m][h]) begin
              found = 1'b1;
              ejob_d = J_FLUSH;
              em_d = 1'(m);
              eh_d = 1'(h);
              eaddr_d = wbase_q[m][h];
              elen_d = wcnt_q[m][h];
              wpend_d[m][h] = 1'b0;
            end
          end
        end
        for (int m = 0; m < 2; m++) begin
          for (int h = 0; h < 2; h++) begin
            if (!found && rpend_q[m][h]) begin
              found = 1'b1;
              ejob_d = J_FILL;
              em_d = 1'(m);
              eh_d = 1'(h);
              eaddr_d = rbase_q[m][h];
              elen_d = 4'(HALF_WORDS);
              rpend_d[m][h] = 1'b0;
            end
          end
        end
        for (int m = 0; m < 2; m++) begin
          if (!found && srd[m]) begin
            found = 1'b1;
            ejob_d = J_SRD;
            em_d = 1'(m);
            eaddr_d = SB_REQ[m].addr;
            elen_d = 4'h1;
          end
        end
        if (found) begin
          est_d = E_CMD;
          ebeat_d = 3'h0;
        end
      end
      E_CMD: begin
        MC_CMD_VALID = 1'b1;
        if (MC_CMD_READY) est_d = E_DATA;
      end
      E_DATA: begin
        beat = (ejob_q == J_SWR || ejob_q == J_FLUSH) ? MC_WREADY : MC_RVALID;
        if (beat) begin
          ebeat_d = 3'(ebeat_q + 3'h1);
          rm_we = ejob_q == J_FILL;
          if ({1'b0, ebeat_q} == 4'(elen_q - 4'h1)) begin
            est_d = E_IDLE;
            case (ejob_q)
              J_SWR: sw_d = 1'b0;
              J_FLUSH: wcnt_d[em_q][eh_q] = 4'h0;
              J_FILL: rvld_d[em_q][eh_q] = 1'b1;
              default: begin
                // A maintenance stall drops the answer; the held request reissues later.
                if (!maint_q[INV_LSB+em_q] && !maint_q[FL_LSB+em_q]) begin
                  SB_ACK[em_q] = 1'b1;
                  SB_RDATA[em_q] = MC_RDATA;
                end
              end
            endcase
          end
        end
      end
      default: est_d = E_IDLE;
    endcase
    // Register bus: address and data taken in either order, then one response.
    AXI_AWREADY = !awv_q && !bv_q;
    AXI_WREADY  = !wv_q && !bv_q;
    AXI_ARREADY = !rv_q;
    if (AXI_AWVALID && AXI_AWREADY) begin
      awv_d = 1'b1;
      awa_d = AXI_AWADDR;
    end
    if (AXI_WVALID && AXI_WREADY) begin
      wv_d = 1'b1;
      wd_d = AXI_WDATA;
      ws_d = AXI_WSTRB;
    end
    if (awv_q && wv_q) begin
      awv_d = 1'b0;
      wv_d = 1'b0;
      bv_d = 1'b1;
      bresp_d = RESP_OKAY;
      case (awa_q)
        OFF_BURST_CTRL: begin
          for (int b = 0; b < 3; b++) begin
            if (ws_q[b]) ctrl_d[8*b+:8] = wd_q[8*b+:8];
          end
          ctrl_d = ctrl_d & CTRL_MASK;
        end
        OFF_MAINT: if (ws_q[0]) maint_d = maint_d | wd_q[3:0];
        OFF_STATUS: bresp_d = RESP_OKAY;
        default: bresp_d = RESP_DECERR;
      endcase
    end
    if (bv_q && AXI_BREADY) bv_d = 1'b0;
    if (rv_q && AXI_RREADY) rv_d = 1'b0;
    if (AXI_ARVALID && AXI_ARREADY) begin
      rv_d = 1'b1;
      rresp_d = RESP_OKAY;
      case (AXI_ARADDR)
        OFF_BURST_CTRL: rdat_d = 32'(ctrl_q);
        OFF_MAINT: rdat_d = 32'(maint_q);
        OFF_STATUS: rdat_d = 32'({rvld_q, wcur_q, sw_q, est_q != E_IDLE});
        default: begin
          rdat_d = 32'h0000_0000;
          rresp_d = RESP_DECERR;
        end
      endcase
    end
  end

  assign AXI_BVALID = bv_q;
  assign AXI_BRESP  = bresp_q;
  assign AXI_RVALID = rv_q;
  assign AXI_RDATA  = rdat_q;
  assign AXI_RRESP  = rresp_q;
  assign MC_CMD     = '{wr: ejob_q == J_SWR || ejob_q == J_FLUSH, addr: eaddr_q, len: elen_q};
  assign MC_WDATA   = (ejob_q == J_SWR) ? swd_q : wmem_q[em_q][{eh_q, ebeat_q}];

  // Buffer storage holds no reset; valid flags and counts guard stale words.
  always_ff @(posedge CLK) begin
    for (int m = 0; m < 2; m++) begin
      if (wm_we[m]) wmem_q[m][wm_idx[m]] <= SB_REQ[m].wdata;
    end
    if (rm_we) rmem_q[em_q][{eh_q, ebeat_q}] <= MC_RDATA;
  end

  // Control state.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rbase_q <= '{default: '0};
      wbase_q <= '{default: '0};
      wcnt_q  <= '{default: '0};
      rvld_q  <= '0;
      rseen_q <= '0;
      rpend_q <= '0;
      wpend_q <= '0;
      wcur_q  <= '0;
      sw_q    <= 1'b0;
      swa_q   <= '0;
      swd_q   <= '0;
      ctrl_q  <= BURST_CTRL_RST;
      maint_q <= '0;
      est_q   <= E_IDLE;
      ejob_q  <= J_SWR;
      em_q    <= 1'b0;
      eh_q    <= 1'b0;
      elen_q  <= '0;
      eaddr_q <= '0;
      ebeat_q <= '0;
      awv_q   <= 1'b0;
      awa_q   <= '0;
      wv_q    <= 1'b0;
      wd_q    <= '0;
      ws_q    <= '0;
      bv_q    <= 1'b0;
      bresp_q <= RESP_OKAY;
      rv_q    <= 1'b0;
      rdat_q  <= '0;
      rresp_q <= RESP_OKAY;
    end else begin
      rbase_q <= rbase_d;
      wbase_q <= wbase_d;
      wcnt_q  <= wcnt_d;
      rvld_q  <= rvld_d;
      rseen_q <= rseen_d;
      rpend_q <= rpend_d;
      wpend_q <= wpend_d;
      wcur_q  <= wcur_d;
      sw_q    <= sw_d;
      swa_q   <= swa_d;
      swd_q   <= swd_d;
      ctrl_q  <= ctrl_d;
      maint_q <= maint_d;
      est_q   <= est_d;
      ejob_q  <= ejob_d;
      em_q    <= em_d;
      eh_q    <= eh_d;
      elen_q  <= elen_d;
      eaddr_q <= eaddr_d;
      ebeat_q <= ebeat_d;
      awv_q   <= awv_d;
      awa_q   <= awa_d;
      wv_q    <= wv_d;
      wd_q    <= wd_d;
      ws_q    <= ws_d;
      bv_q    <= bv_d;
      bresp_q <= bresp_d;
      rv_q    <= rv_d;
      rdat_q  <= rdat_d;
      rresp_q <= rresp_d;
    end
  end

  // Checks on the controller side and the bus lanes.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  property p_fill_len;
    est_q == E_CMD && ejob_q == J_FILL |-> MC_CMD.len == 4'(HALF_WORDS);
  endproperty
  a_fill_len: assert property (p_fill_len) else $error("fill burst not eight beats");
  property p_wr_len;
    est_q == E_CMD && ejob_q == J_FLUSH |-> MC_CMD.len >= 4'h1 && MC_CMD.len <= 4'(HALF_WORDS);
  endproperty
  a_wr_len: assert property (p_wr_len) else $error("burst write length out of range");
  property p_rd_zero;
    SB_ACK == 2'b00 |-> SB_RDATA == '0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data not zero when idle");
  property p_inv_stall;
    maint_q[INV_LSB] |-> !SB_ACK[0];
  endproperty
  a_inv_stall: assert property (p_inv_stall) else $error("ack during invalidate");
  property p_flush_stall;
    maint_q[FL_LSB+1] |-> !SB_ACK[1];
  endproperty
  a_flush_stall: assert property (p_flush_stall) else $error("ack during flush");
  property p_sw_hold;
    sw_q && est_q == E_IDLE |-> SB_ACK == 2'b00 ##1 est_q == E_CMD && ejob_q == J_SWR;
  endproperty
  a_sw_hold: assert property (p_sw_hold) else $error("single write not issued first");
  property p_sw_take;
    SB_ACK[0] && SB_REQ[0].wr && !in_scope(ctrl_q, SB_REQ[0].addr)
      |=> sw_q && swd_q == $past(SB_REQ[0].wdata);
  endproperty
  a_sw_take: assert property (p_sw_take) else $error("single write not latched");
  property p_fill_done;
    est_q == E_DATA && ejob_q == J_FILL && MC_RVALID && ebeat_q == 3'h7 && !em_q && !eh_q
      |=> rvld_q[0][0] && est_q == E_IDLE;
  endproperty
  a_fill_done: assert property (p_fill_done) else $error("filled half not valid");
endmodule
`default_nettype wire

//--- dv/ebb_mc_model.sv
// Behavioural memory controller that answers the burst buffer's commands.
`default_nettype none
module ebb_mc_model (
  // Clock, reset and a stall that makes commands wait.
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 stall,
  // Command and data lanes.
  input  wire logic                 cmd_valid,
  output logic                      cmd_ready,
  input  wire ebb_pkg::ebb_mc_cmd_t cmd,
  input  wire ebb_pkg::ebb_word_t   wdata,
  output logic                      wready,
  output logic                      rvalid,
  output ebb_pkg::ebb_word_t        rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import ebb_pkg::*;
  ebb_word_t   mem [ebb_addr_t];
  ebb_mc_cmd_t last;
  ebb_addr_t   at;
  logic        busy;
  int          left;
  // One job at a time; a new command waits while a job runs or stall is up.
  assign cmd_ready = !busy && !stall;
  // Between beats the read lane toggles, so stale data never looks valid.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 0;
      wready <= 0;
      rvalid <= 0;
      rdata <= '0;
    end else begin
      rdata <= ~rdata;
      rvalid <= 0;
      wready <= busy && last.wr && !(wready && left == 1);
      if (!busy && cmd_valid && cmd_ready) begin
        busy <= 1;
        last <= cmd;
        at <= cmd.addr;
        left <= int'(cmd.len);
      end else if (busy && !last.wr) begin
        rvalid <= 1;
        rdata <= mem.exists(at) ? mem[at] : at[23:0] ^ 24'h5A_5A5A;
        at <= at + 1;
        left <= left - 1;
        busy <= left != 1;
      end else if (wready) begin
        mem[at] = wdata;
        at <= at + 1;
        left <= left - 1;
        busy <= left != 1;
      end
    end
  end
endmodule
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench for the external memory burst buffer.
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ebb_pkg::*;
  logic              clk = 0, rst_n = 0, stall = 0, awv = 0, wv = 0, bry = 0;
  logic              arv = 0, rry = 0, awr, wrd, bv, arr, rv, mcv, mcr, mwr, mrv;
  logic [1:0]        bresp, rresp, ack, br;
  logic [31:0]       awa = 0, wd = 0, ara = 0, rd;
  ebb_sb_req_t [1:0] req = '0;
  ebb_word_t [1:0]   srd;
  ebb_mc_cmd_t       cmd;
  ebb_word_t         mwd, mrd;
  int                num_errors = 0, checks = 0;
  ebb_top i_dut (.CLK(clk), .RST_N(rst_n), .AXI_AWADDR(awa), .AXI_AWVALID(awv),
    .AXI_AWREADY(awr), .AXI_WDATA(wd), .AXI_WSTRB(4'hF), .AXI_WVALID(wv), .AXI_WREADY(wrd),
    .AXI_BRESP(bresp), .AXI_BVALID(bv), .AXI_BREADY(bry), .AXI_ARADDR(ara),
    .AXI_ARVALID(arv), .AXI_ARREADY(arr), .AXI_RDATA(rd), .AXI_RRESP(rresp),
    .AXI_RVALID(rv), .AXI_RREADY(rry), .SB_REQ(req), .SB_ACK(ack), .SB_RDATA(srd),
    .MC_CMD_VALID(mcv), .MC_CMD_READY(mcr), .MC_CMD(cmd), .MC_WDATA(mwd),
    .MC_WREADY(mwr), .MC_RVALID(mrv), .MC_RDATA(mrd));
  ebb_mc_model i_mc (.clk(clk), .rst_n(rst_n), .stall(stall), .cmd_valid(mcv),
    .cmd_ready(mcr), .cmd(cmd), .wdata(mwd), .wready(mwr), .rvalid(mrv), .rdata(mrd));
  // Free-running system clock.
  initial begin
    forever #2.5 clk = ~clk;
  end
  function automatic ebb_word_t pat(ebb_addr_t a);
    return a[23:0] ^ 24'h5A_5A5A;
  endfunction
  // Register write: address and data offered together, each dropped when taken.
  task automatic axw(input logic [31:0] a, d);
    bit pa, pw, ga, gw;
    pa = 1;
    pw = 1;
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    bry <= 1;
    while (pa || pw) begin
      @(negedge clk);
      ga = pa && awr;
      gw = pw && wrd;
      @(posedge clk);
      if (ga) begin
        awv <= 0;
        pa = 0;
      end
      if (gw) begin
        wv <= 0;
        pw = 0;
      end
    end
    do @(negedge clk); while (!bv);
    br = bresp;
    @(posedge clk);
    bry <= 0;
    @(posedge clk);
  endtask
  task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    ara <= a;
    arv <= 1;
    rry <= 1;
    do @(negedge clk); while (!arr);
    @(posedge clk);
    arv <= 0;
    do @(negedge clk); while (!rv);
    d = rd;
    r = rresp;
    @(posedge clk);
    rry <= 0;
    @(posedge clk);
  endtask
  // Shared-bus access; n counts the wait states before the acknowledge.
  task automatic sb(input int m, input logic w, input ebb_addr_t a, input ebb_word_t d,
                    output ebb_word_t q, output int n);
    req[m] <= '{1'b1, w, a, d};
    n = 0;
    forever begin
      @(negedge clk);
      if (ack[m] === 1'b1) break;
      n++;
    end
    q = srd[m];
    @(posedge clk);
    req[m] <= '0;
    @(posedge clk);
  endtask
  // Polls the maintenance register until the given bit has cleared itself.
  task automatic clr(input int b);
    logic [31:0] v;
    logic [1:0]  r;
    do axr(OFF_MAINT, v, r); while (v[b] !== 1'b0);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // A hang must not hide a failure, so the watchdog ends in the same verdict.
  initial begin
    #200us;
    num_errors++;
    finish_test();
  end
  initial begin
    logic [31:0] v;
    logic [1:0]  r;
    ebb_word_t   q;
    int          n;
    repeat (12) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    axr(OFF_BURST_CTRL, v, r);
    `CHK(v, 32'h0000_0000);
    axw(OFF_BURST_CTRL, 32'h00FF_FFFF);
    `CHK(br, RESP_OKAY);
    axr(OFF_BURST_CTRL, v, r);
    `CHK(v, {8'h00, CTRL_MASK});
    axr(32'h0000_0010, v, r);
    `CHK(r, RESP_DECERR);
    axw(32'h0000_0010, 32'h0000_0000);
    `CHK(br, RESP_DECERR);
    axr(OFF_STATUS, v, r);
    `CHK(v, 32'h0000_0000);
    $display("test regs done");
    sb(0, 0, 26'h010_0010, '0, q, n);
    `CHK(q, pat(26'h010_0010));
    `CHK(i_mc.last.len, 4'h1);
    @(negedge clk);
    `CHK(srd[0], 24'h00_0000);
    @(posedge clk);
    stall <= 1;
    sb(0, 1, 26'h010_0040, 24'h12_3456, q, n);
    `CHK(n, 0);
    fork
      begin
        repeat (20) @(posedge clk);
        stall <= 0;
      end
    join_none
    sb(1, 0, 26'h010_0020, '0, q, n);
    `CHK(n > 18, 1'b1);
    `CHK(i_mc.mem[26'h010_0040], 24'h12_3456);
    $display("test single done");
    axw(OFF_BURST_CTRL, 32'h0000_0020);
    sb(0, 0, 26'h000_1000, '0, q, n);
    `CHK(q, pat(26'h000_1000));
    `CHK(i_mc.last.len, 4'h8);
    sb(0, 0, 26'h000_1001, '0, q, n);
    `CHK({q, n}, {pat(26'h000_1001), 32'd0});
    repeat (30) @(posedge clk);
    `CHK(i_mc.last.addr, 26'h000_1008);
    sb(0, 0, 26'h100_1000, '0, q, n);
    sb(0, 0, 26'h000_1009, '0, q, n);
    `CHK({q, n}, {pat(26'h000_1009), 32'd0});
    axw(OFF_MAINT, 32'h0000_0001);
    clr(0);
    sb(0, 0, 26'h000_1002, '0, q, n);
    `CHK(n > 0, 1'b1);
    $display("test burst read done");
    for (int k = 0; k < 9; k++) begin
      sb(1, 1, 26'h000_8000 + k, 24'hC0_0000 + k, q, n);
      `CHK(n, 0);
    end
    repeat (30) @(posedge clk);
    `CHK({i_mc.last.wr, i_mc.last.len}, 5'h18);
    sb(1, 1, 26'h000_8040, 24'hAB_CDEF, q, n);
    repeat (30) @(posedge clk);
    `CHK({i_mc.last.addr, i_mc.last.len}, {26'h000_8008, 4'h1});
    for (int k = 0; k < 9; k++) begin
      `CHK(i_mc.mem[26'h000_8000 + k], ebb_word_t'(24'hC0_0000 + k));
    end
    axw(OFF_MAINT, 32'h0000_0008);
    clr(3);
    `CHK(i_mc.mem[26'h000_8040], 24'hAB_CDEF);
    $display("test burst write done");
    axw(OFF_BURST_CTRL, 32'h0000_1120);
    sb(1, 0, 26'h110_0000, '0, q, n);
    `CHK({q, i_mc.last.len}, {pat(26'h110_0000), 4'h1});
    sb(1, 0, 26'h120_0000, '0, q, n);
    `CHK({q, i_mc.last.len}, {pat(26'h120_0000), 4'h8});
    $display("test modes done");
    finish_test();
  end
endmodule
`default_nettype wire
